//--- verilog/dmsp_host.sv
`timescale 1ns/100ps
`include "dmsp_cfg.svh"
module dmsp_host
  import dmsp_pkg::*;
#(
  parameter int QTR_CYC = `DMSP_QTR_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // user command port
  input  wire logic        mode_3wire,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_read,
  input  wire logic        cmd_wide,
  input  wire logic [7:0]  cmd_sub,
  input  wire logic [15:0] cmd_wdata,
  output      logic        cmd_ready,
  output      logic        rsp_valid,
  output      logic [7:0]  rsp_rdata,
  output      logic        rsp_nack,
  output      logic        rsp_err,
  // user power control and wake report
  input  wire logic        power_on,
  output      logic        wake_irq,
  output      logic        wake_level,
  // device bus pins
  output      logic        bus_format_strap,
  output      logic        serial_clock_line,
  input  wire logic        serial_data_in,
  output      logic        serial_data_out,
  output      logic        serial_data_oe_n,
  output      logic        select_n,
  // device wake pin
  input  wire logic        wake_pin_in,
  output      logic        wake_pin_out,
  output      logic        wake_pin_oe_n
);

  dmsp_tick_if tk ();

  dmsp_tick #(
    .QTR_CYC (QTR_CYC)
  ) u_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tk      (tk)
  );

  dmsp_regs_t st;
  dmsp_regs_t next_st;

  // byte loaded into the shifter for each step
  function automatic logic [7:0] byte_for(input logic [1:0] step, input logic rd,
                                          input logic [7:0] sub, input logic [15:0] wd);
    logic [7:0] b;
    b = `DMSP_RX_FILL;
    case (step)
      `DMSP_STEP_ADDR: b = {`DMSP_CHIP_ADDR, 1'b0};
      `DMSP_STEP_SUB:  b = sub;
      `DMSP_STEP_HI:   b = rd ? {`DMSP_CHIP_ADDR, 1'b1} : wd[15:8];
      default:         b = rd ? `DMSP_RX_FILL : wd[7:0];
    endcase
    return b;
  endfunction

  // sub-address legality per mode and direction
  function automatic logic sub_ok(input logic three, input logic rd, input logic [7:0] sub);
    logic ok;
    ok = 1'b0;
    if (rd) begin
      ok = (sub == `DMSP_RD_SUB_A) || (sub == `DMSP_RD_SUB_B);
    end else if (three) begin
      ok = (sub <= `DMSP_3W_SUB_LO_MAX) ||
           ((sub >= `DMSP_3W_SUB_HI_MIN) && (sub <= `DMSP_SUB_MAX));
    end else begin
      ok = (sub <= `DMSP_SUB_MAX);
    end
    return ok;
  endfunction

  logic       rx_byte;
  logic       drive;
  logic [3:0] last_bit;

  assign tk.run = (st.state != DMSP_IDLE);

  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.wake_irq  = 1'b0;
    rx_byte           = st.rd && (st.step == `DMSP_STEP_LAST);
    drive             = !rx_byte && (st.bitn < `DMSP_DATA_BITS);
    last_bit          = st.three ? `DMSP_LAST_3W : `DMSP_ACK_BIT;

    // pin synchronisers with agreement filter
    next_st.s1 = serial_data_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.sf = st.s3;
    end
    next_st.w1 = wake_pin_in;
    next_st.w2 = st.w1;
    next_st.w3 = st.w2;
    if (st.w2 == st.w3) begin
      next_st.wf = st.w3;
    end

    // wake pin: pulled low to keep the device on, released to let it power down
    next_st.wake_oe_n = !power_on;
    if (st.wf && (st.w2 == st.w3) && !st.w3 && st.wake_oe_n) begin
      next_st.wake_irq = 1'b1;
    end

    case (st.state)
      DMSP_IDLE: begin
        next_st.strap    = mode_3wire;
        next_st.scl      = !mode_3wire;
        next_st.en_n     = 1'b1;
        next_st.sda_oe_n = 1'b1;
        if (cmd_valid && st.ready) begin
          next_st.three = st.strap;
          next_st.rd    = cmd_read;
          next_st.wide  = cmd_wide && !cmd_read;
          next_st.sub   = cmd_sub;
          next_st.wdata = cmd_wdata;
          next_st.nack  = 1'b0;
          next_st.err   = 1'b0;
          next_st.q     = `DMSP_Q_SET;
          next_st.step  = st.strap ? `DMSP_STEP_SUB : `DMSP_STEP_ADDR;
          if (!sub_ok(st.strap, cmd_read, cmd_sub)) begin
            next_st.err   = 1'b1;
            next_st.state = DMSP_DONE;
          end else begin
            next_st.state = DMSP_START;
          end
        end
      end
      DMSP_START: begin
        if (tk.tick) begin
          next_st.q = st.q + 1'b1;
          case (st.q)
            `DMSP_Q_SET: begin
              if (st.three) begin
                next_st.en_n = 1'b0;
              end else begin
                next_st.sda_oe_n = 1'b1;
              end
            end
            `DMSP_Q_RISE: begin
              if (!st.three) begin
                next_st.scl = 1'b1;
              end
            end
            `DMSP_Q_SAMPLE: begin
              // open drain: the line may only ever be pulled low
              if (!st.three) begin
                next_st.sda_out  = 1'b0;
                next_st.sda_oe_n = 1'b0;
              end
            end
            default: begin
              next_st.scl   = 1'b0;
              next_st.bitn  = '0;
              next_st.shreg = byte_for(st.step, st.rd, st.sub, st.wdata);
              next_st.state = DMSP_BYTE;
            end
          endcase
        end
      end
      DMSP_BYTE: begin
        if (tk.tick) begin
          next_st.q = st.q + 1'b1;
          case (st.q)
            `DMSP_Q_SET: begin
              // data moves only while the clock is low
              if (st.three) begin
                next_st.sda_oe_n = !drive;
                next_st.sda_out  = st.shreg[7];
              end else begin
                next_st.sda_oe_n = !(drive && !st.shreg[7]);
                next_st.sda_out  = 1'b0;
              end
            end
            `DMSP_Q_RISE: begin
              next_st.scl = 1'b1;
            end
            `DMSP_Q_SAMPLE: begin
              if (st.bitn == `DMSP_ACK_BIT) begin
                if (!rx_byte && st.sf) begin
                  next_st.nack = 1'b1;
                end
              end else if (rx_byte) begin
                next_st.shreg = {st.shreg[6:0], st.sf};
              end
            end
            default: begin
              next_st.scl = st.three ? 1'b0 : 1'b0;
              if (!rx_byte) begin
                next_st.shreg = {st.shreg[6:0], 1'b1};
              end
              if (st.bitn != last_bit) begin
                next_st.bitn = st.bitn + 1'b1;
              end else begin
                next_st.bitn = '0;
                if (st.nack) begin
                  next_st.state = DMSP_STOP;
                end else begin
                  case (st.step)
                    `DMSP_STEP_ADDR: begin
                      next_st.step  = `DMSP_STEP_SUB;
                      next_st.shreg = st.sub;
                    end
                    `DMSP_STEP_SUB: begin
                      if (st.rd && !st.three) begin
                        next_st.step  = `DMSP_STEP_HI;
                        next_st.state = DMSP_START;
                      end else if (st.rd || !st.wide) begin
                        next_st.step  = `DMSP_STEP_LAST;
                        next_st.shreg = byte_for(`DMSP_STEP_LAST, st.rd, st.sub, st.wdata);
                      end else begin
                        next_st.step  = `DMSP_STEP_HI;
                        next_st.shreg = st.wdata[15:8];
                      end
                    end
                    `DMSP_STEP_HI: begin
                      next_st.step  = `DMSP_STEP_LAST;
                      next_st.shreg = byte_for(`DMSP_STEP_LAST, st.rd, st.sub, st.wdata);
                    end
                    default: begin
                      if (st.rd) begin
                        next_st.rdata = st.shreg;
                      end
                      next_st.state = DMSP_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      DMSP_STOP: begin
        if (tk.tick) begin
          next_st.q = st.q + 1'b1;
          case (st.q)
            `DMSP_Q_SET: begin
              next_st.sda_oe_n = st.three;
            end
            `DMSP_Q_RISE: begin
              if (!st.three) begin
                next_st.scl = 1'b1;
              end
            end
            `DMSP_Q_SAMPLE: begin
              next_st.sda_oe_n = 1'b1;
              if (st.three) begin
                next_st.en_n = 1'b1;
              end
            end
            default: begin
              next_st.state = DMSP_DONE;
            end
          endcase
        end
      end
      DMSP_DONE: begin
        next_st.rsp_valid = 1'b1;
        next_st.state     = DMSP_IDLE;
      end
      default: begin
        next_st.state = DMSP_IDLE;
      end
    endcase

    next_st.ready = (next_st.state == DMSP_IDLE) && !(st.state == DMSP_IDLE && cmd_valid && st.ready);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.scl       <= 1'b1;
      st.sda_out   <= 1'b1;
      st.sda_oe_n  <= 1'b1;
      st.en_n      <= 1'b1;
      st.s1        <= 1'b1;
      st.s2        <= 1'b1;
      st.s3        <= 1'b1;
      st.sf        <= 1'b1;
      st.w1        <= 1'b1;
      st.w2        <= 1'b1;
      st.w3        <= 1'b1;
      st.wf        <= 1'b1;
      st.wake_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ready         = st.ready;
  assign rsp_valid         = st.rsp_valid;
  assign rsp_rdata         = st.rdata;
  assign rsp_nack          = st.nack;
  assign rsp_err           = st.err;
  assign wake_irq          = st.wake_irq;
  assign wake_level        = st.wf;
  assign bus_format_strap  = st.strap;
  assign serial_clock_line = st.scl;
  assign serial_data_out   = st.sda_out;
  assign serial_data_oe_n  = st.sda_oe_n;
  assign select_n          = st.en_n;
  assign wake_pin_out      = st.wake_out;
  assign wake_pin_oe_n     = st.wake_oe_n;
endmodule

//--- verilog/dmsp_cfg.svh
`ifndef DMSP_CFG_SVH
`define DMSP_CFG_SVH

// reference clock and serial bit time
`define DMSP_REF_NS        20
`define DMSP_BIT_NS        2500
// least quarter-bit time, rounded up to whole reference cycles
`define DMSP_QTR_CYC       ((`DMSP_BIT_NS / 4 + `DMSP_REF_NS - 1) / `DMSP_REF_NS)
`define DMSP_QTR_CNT_W     12

// target address and sub-address ranges
`define DMSP_CHIP_ADDR     7'h70
`define DMSP_SUB_MAX       8'h0F
`define DMSP_3W_SUB_LO_MAX 8'h08
`define DMSP_3W_SUB_HI_MIN 8'h0D
`define DMSP_RD_SUB_A      8'h80
`define DMSP_RD_SUB_B      8'h81
`define DMSP_RX_FILL       8'hFF

// bit positions within a byte slot
`define DMSP_DATA_BITS     4'h8
`define DMSP_ACK_BIT       4'h8
`define DMSP_LAST_3W       4'h7

// byte steps of a transfer
`define DMSP_STEP_ADDR     2'h0
`define DMSP_STEP_SUB      2'h1
`define DMSP_STEP_HI       2'h2
`define DMSP_STEP_LAST     2'h3

// quarters of one bit slot
`define DMSP_Q_SET         2'h0
`define DMSP_Q_RISE        2'h1
`define DMSP_Q_SAMPLE      2'h2
`define DMSP_Q_FALL        2'h3

`endif

//--- verilog/dmsp_pkg.sv
`include "dmsp_cfg.svh"
package dmsp_pkg;

  typedef enum logic [2:0] {
    DMSP_IDLE,
    DMSP_START,
    DMSP_BYTE,
    DMSP_STOP,
    DMSP_DONE
  } dmsp_state_t;

  typedef struct packed {
    dmsp_state_t state;
    logic [1:0]  q;
    logic [3:0]  bitn;
    logic [1:0]  step;
    logic [7:0]  shreg;
    logic        rd;
    logic        wide;
    logic        three;
    logic [7:0]  sub;
    logic [15:0] wdata;
    logic [7:0]  rdata;
    logic        nack;
    logic        err;
    logic        rsp_valid;
    logic        ready;
    logic        scl;
    logic        sda_out;
    logic        sda_oe_n;
    logic        en_n;
    logic        strap;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        sf;
    logic        w1;
    logic        w2;
    logic        w3;
    logic        wf;
    logic        wake_out;
    logic        wake_oe_n;
    logic        wake_irq;
  } dmsp_regs_t;

  typedef struct packed {
    logic [`DMSP_QTR_CNT_W-1:0] cnt;
    logic                       tick;
  } dmsp_tick_regs_t;

endpackage

//--- verilog/dmsp_tick_if.sv
`timescale 1ns/100ps
interface dmsp_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport ctl (output run, input tick);
endinterface

//--- verilog/dmsp_tick.sv
`timescale 1ns/100ps
`include "dmsp_cfg.svh"
module dmsp_tick
  import dmsp_pkg::*;
#(
  parameter int QTR_CYC = `DMSP_QTR_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // quarter-bit pulse
  dmsp_tick_if.gen  tk
);
  localparam logic [`DMSP_QTR_CNT_W-1:0] LAST = `DMSP_QTR_CNT_W'(QTR_CYC - 1);

  generate
    if (QTR_CYC < 2 || QTR_CYC >= (1 << `DMSP_QTR_CNT_W)) begin : g_bad
      $error("dmsp_tick: QTR_CYC out of range");
    end
  endgenerate

  dmsp_tick_regs_t st;
  dmsp_tick_regs_t next_st;

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    // held in phase with the start of each command
    if (!tk.run) begin
      next_st.cnt = '0;
    end else if (st.cnt == LAST) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.tick = st.tick;
endmodule

//--- testbench/dmsp_host_properties.sv
`timescale 1ns/100ps
module dmsp_host_properties #(
  parameter int QTR_CYC = 32
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // command side
  input wire logic       cmd_valid,
  input wire logic       cmd_read,
  input wire logic [7:0] cmd_sub,
  input wire logic       cmd_ready,
  input wire logic       rsp_valid,
  input wire logic       rsp_err,
  // pins
  input wire logic       power_on,
  input wire logic       wake_pin_oe_n,
  input wire logic       bus_format_strap,
  input wire logic       serial_clock_line,
  input wire logic       serial_data_out,
  input wire logic       serial_data_oe_n,
  input wire logic       select_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_ready_drop: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready held after accept");
  chk_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
  chk_ready_back: assert property (
    rsp_valid |=> cmd_ready) else $error("ready late after response");
  chk_strap_hold: assert property (
    !cmd_ready && !$past(cmd_ready) |-> $stable(bus_format_strap)) else $error("strap moved in transfer");
  chk_data_clk_low: assert property (
    bus_format_strap && !serial_data_oe_n && $changed(serial_data_out)
    |-> !serial_clock_line && !$past(serial_clock_line)) else $error("data moved with clock high");
  chk_open_drain: assert property (
    !bus_format_strap && !serial_data_oe_n |-> !serial_data_out) else $error("data driven high");
  chk_clk_selected: assert property (
    bus_format_strap && $rose(serial_clock_line) |-> !select_n) else $error("clock without select");
  chk_bad_read: assert property (
    cmd_valid && cmd_ready && cmd_read && cmd_sub != 8'h80 && cmd_sub != 8'h81
    |-> ##[2:3] (rsp_valid && rsp_err)) else $error("bad read not refused");
  chk_i2c_idle: assert property (
    cmd_ready && !bus_format_strap && !$past(bus_format_strap) && !$past(bus_format_strap, 2)
    |-> serial_clock_line && serial_data_oe_n) else $error("bus not idle");
  chk_3w_idle: assert property (
    cmd_ready && bus_format_strap && $past(bus_format_strap) && $past(bus_format_strap, 2)
    |-> select_n && !serial_clock_line) else $error("select not idle");
  chk_wake_on: assert property (
    power_on [*3] |-> !wake_pin_oe_n) else $error("wake pin not pulled");
  chk_wake_off: assert property (
    !power_on [*3] |-> wake_pin_oe_n) else $error("wake pin pulled");
endmodule

bind dmsp_host dmsp_host_properties #(.QTR_CYC(QTR_CYC)) i_dmsp_host_properties (
  .ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_sub(cmd_sub),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .power_on(power_on),
  .wake_pin_oe_n(wake_pin_oe_n), .bus_format_strap(bus_format_strap), .serial_clock_line(serial_clock_line),
  .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n), .select_n(select_n));

//--- testbench/dmsp_dev_model.sv
`timescale 1ns/100ps
module dmsp_dev_model #(
  parameter logic [7:0] RD_A = 8'h5A,
  parameter logic [7:0] RD_B = 8'hC3
) (
  // bus pins
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic        strap,
  input  wire logic        en_n,
  output      logic        sda_oe,
  output      logic        sda_o,
  // wake pin
  input  wire logic        wake,
  output      logic        wake_low,
  // scenario control and observation
  input  wire logic        nack_en,
  input  wire logic        irq_req,
  output      logic        dev_on,
  output      logic [7:0]  last_sub,
  output      logic [15:0] wdata,
  output      int          n_in
);
  logic [7:0] b;
  logic [7:0] rsel;
  bit         pend;
  initial begin
    sda_oe = 1'h0;
    sda_o = 1'h1;
    pend = 1'h0;
  end
  // irq_req stands for a self-polling detector whose rate and strength checks both pass
  assign wake_low = irq_req;
  assign dev_on = !wake;
  // timed by the bus clock alone
  task automatic rx8();
    repeat (8) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask
  task automatic put(input logic v);
    @(negedge scl);
    sda_oe = 1'h1;
    sda_o = v;
  endtask
  task automatic ack();
    put(1'h0);
    @(negedge scl);
    sda_oe = 1'h0;
  endtask
  always @(negedge sda) if (scl === 1'h1 && !strap) begin
    disable i2c_xfer;
    pend = 1'h1;
  end
  always @(posedge sda) if (scl === 1'h1 && !strap) begin
    disable i2c_xfer;
    sda_oe = 1'h0;
  end
  initial forever begin
    wait (pend);
    pend = 1'h0;
    begin : i2c_xfer
      rx8();
      if (b[7:1] != 7'h70 || nack_en) disable i2c_xfer;
      if (b[0]) begin
        put(1'h0);
        for (int i = 7; i >= 0; i--) put(rsel[i]);
        @(negedge scl);
        sda_oe = 1'h0;
      end else begin
        ack();
        rx8();
        last_sub = b;
        rsel = b[0] ? RD_B : RD_A;
        n_in = 0;
        ack();
        forever begin
          rx8();
          ack();
          wdata = {wdata[7:0], b};
          n_in++;
        end
      end
    end
  end
  always @(posedge en_n) begin
    disable tw_xfer;
    sda_oe = 1'h0;
  end
  always @(negedge en_n) if (strap) begin : tw_xfer
    rx8();
    last_sub = b;
    n_in = 0;
    if (b == 8'h80 || b == 8'h81) begin
      rsel = b[0] ? RD_B : RD_A;
      for (int i = 7; i >= 0; i--) put(rsel[i]);
    end else forever begin
      @(posedge scl);
      wdata = {wdata[14:0], sda};
      n_in++;
    end
  end
endmodule

//--- testbench/dmsp_host_tb.sv
`timescale 1ns/100ps
module dmsp_host_tb;
  localparam logic [7:0] RD_A = 8'h5A;
  localparam logic [7:0] RD_B = 8'hC3;
  logic        ref_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        mode_3wire = 1'h0;
  logic        cmd_valid = 1'h0;
  logic        cmd_read = 1'h0;
  logic        cmd_wide = 1'h0;
  logic [7:0]  cmd_sub = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        power_on = 1'h0;
  logic        nack_en = 1'h0;
  logic        irq_req = 1'h0;
  logic        cmd_ready, rsp_valid, rsp_nack, rsp_err, wake_irq, wake_level, strap, scl;
  logic        sda_out, sda_oe_n, select_n, wake_out, wake_oe_n, dev_oe, dev_o, wake_low, dev_on;
  logic [7:0]  rsp_rdata, last_sub;
  logic [15:0] dev_wdata;
  int          n_in;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          irq_cnt = 0;
  wire         sda = (sda_oe_n ? 1'h1 : sda_out) & (dev_oe ? dev_o : 1'h1);
  wire         wake = (wake_oe_n ? 1'h1 : wake_out) & !wake_low;

  dmsp_host #(.QTR_CYC(2)) i_dmsp_host (
    .ref_clk(ref_clk), .rstn(rstn), .mode_3wire(mode_3wire), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_wide(cmd_wide), .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .rsp_err(rsp_err),
    .power_on(power_on), .wake_irq(wake_irq), .wake_level(wake_level), .bus_format_strap(strap),
    .serial_clock_line(scl), .serial_data_in(sda), .serial_data_out(sda_out), .serial_data_oe_n(sda_oe_n),
    .select_n(select_n), .wake_pin_in(wake), .wake_pin_out(wake_out), .wake_pin_oe_n(wake_oe_n));
  dmsp_dev_model #(.RD_A(RD_A), .RD_B(RD_B)) i_dmsp_dev_model (
    .scl(scl), .sda(sda), .strap(strap), .en_n(select_n), .sda_oe(dev_oe), .sda_o(dev_o), .wake(wake),
    .wake_low(wake_low), .nack_en(nack_en), .irq_req(irq_req), .dev_on(dev_on), .last_sub(last_sub),
    .wdata(dev_wdata), .n_in(n_in));

  always #10 ref_clk = ~ref_clk;

  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (wake_irq === 1'h1) irq_cnt <= irq_cnt + 1;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_cmd(input logic th, input logic rd, input logic wd, input logic [7:0] s,
                        input logic [15:0] d);
    @(posedge ref_clk);
    mode_3wire <= th;
    repeat (4) @(posedge ref_clk);
    cmd_valid <= 1'h1;
    cmd_read <= rd;
    cmd_wide <= wd;
    cmd_sub <= s;
    cmd_wdata <= d;
    do @(negedge ref_clk); while (cmd_ready !== 1'h1);
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    while (rsp_valid !== 1'h1) @(negedge ref_clk);
  endtask

  task automatic t_i2c_write();
    do_cmd(1'h0, 1'h0, 1'h0, 8'h0F, 16'h77A5);
    check(16'(last_sub), 16'h000F);
    check({8'h00, dev_wdata[7:0]}, 16'h00A5);
    check(16'(n_in), 16'h0001);
    check(16'(rsp_nack), 16'h0000);
    do_cmd(1'h0, 1'h0, 1'h1, 8'h00, 16'h1234);
    check(dev_wdata, 16'h1234);
    check(16'(n_in), 16'h0002);
  endtask

  task automatic t_reads();
    logic [7:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 8'h80 | 8'(i % 2);
      do_cmd(1'(i / 2), 1'h1, 1'h0, s, 16'h0000);
      check(16'(rsp_rdata), 16'(s[0] ? RD_B : RD_A));
      check(16'(last_sub), 16'(s));
    end
  endtask

  task automatic t_3w_write();
    logic [7:0] subs [5] = '{8'h00, 8'h08, 8'h0D, 8'h0E, 8'h0F};
    foreach (subs[i]) begin
      do_cmd(1'h1, 1'h0, 1'h0, subs[i], {8'h00, ~subs[i]});
      check(16'(last_sub), 16'(subs[i]));
      check({8'h00, dev_wdata[7:0]}, {8'h00, ~subs[i]});
      check(16'(n_in), 16'h0008);
    end
    do_cmd(1'h1, 1'h0, 1'h1, 8'h05, 16'hBEEF);
    check(dev_wdata, 16'hBEEF);
    check(16'(n_in), 16'h0010);
  endtask

  task automatic t_refused();
    logic [9:0] bad [5] = '{10'h010, 10'h209, 10'h20C, 10'h182, 10'h37F};
    logic [7:0] ls;
    foreach (bad[i]) begin
      ls = last_sub;
      do_cmd(bad[i][9], bad[i][8], 1'h0, bad[i][7:0], 16'hFFFF);
      check(16'(rsp_err), 16'h0001);
      check(16'(last_sub), 16'(ls));
    end
  endtask

  task automatic t_nack();
    logic [7:0] ls;
    ls = last_sub;
    @(posedge ref_clk);
    nack_en <= 1'h1;
    do_cmd(1'h0, 1'h0, 1'h0, 8'h03, 16'h0011);
    check(16'(rsp_nack), 16'h0001);
    check(16'(last_sub), 16'(ls));
    @(posedge ref_clk);
    nack_en <= 1'h0;
    do_cmd(1'h0, 1'h0, 1'h0, 8'h03, 16'h0011);
    check(16'(rsp_nack), 16'h0000);
    check(16'(last_sub), 16'h0003);
  endtask

  task automatic t_wake();
    @(posedge ref_clk);
    power_on <= 1'h1;
    repeat (6) @(posedge ref_clk);
    check(16'(dev_on), 16'h0001);
    power_on <= 1'h0;
    repeat (8) @(posedge ref_clk);
    check(16'(dev_on), 16'h0000);
    irq_req <= 1'h1;
    repeat (8) @(posedge ref_clk);
    check(16'(wake_level), 16'h0000);
    irq_req <= 1'h0;
    repeat (8) @(posedge ref_clk);
    check(16'(irq_cnt), 16'h0001);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge ref_clk);
    t_i2c_write();
    t_reads();
    t_3w_write();
    t_refused();
    t_nack();
    t_wake();
    stop_test();
  end
endmodule
